//--- src/gpacl_top.sv
// Port A open-drain, analog select, group mux and configuration lock
`timescale 1ns/100ps
// Overview of operation
// - One R/W open-drain bit per pin, reset zero gives push-pull.
// - Open-drain output pin drives low for zero, releases pad for one.
// - Analog bit zero leaves pin under digital configuration.
// - Analog bit one enables the pin's analog function.
// - Analog select at 0x14, resets to all ones.
// - Only pins 28, 21, 20, 13, 12 react to analog select.
// - Reads return stored value, reserved bits included.
// - Group mux low at 0x20, two bits per pin 0-15, reset zero.
// - Group mux high at 0x22, two bits per pin 16-31, reset zero.
// - Function choice combines group-mux and primary-mux fields.
// - Unlocked pin accepts writes to its configuration bits.
// - Locked pin blocks changes to its configuration bits.
// - Lock register at 0x3C, one bit per pin, resets unlocked.
// - Commit bit at 0x3E, once set, freezes that lock bit until reset.
module gpacl_top
  import gpacl_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire gpacl_req_t             bus_req,
  output logic [DW-1:0]               bus_rdata,
  input  wire logic [NPIN*MUX_W-1:0]  primary_mux,
  input  wire logic [NPIN-1:0]        pin_direction,
  input  wire logic [NPIN-1:0]        pin_out_data,
  output logic [NPIN-1:0]             pad_out,
  output logic [NPIN-1:0]             pad_oe_n,
  output logic [NPIN-1:0]             analog_en,
  output logic [NPIN*FUNC_W-1:0]      func_sel,
  output logic [NPIN-1:0]             pin_lock
);
  gpacl_state_t s_q;
  gpacl_state_t s_d;

  logic [NPIN-1:0]        pad_out_w;
  logic [NPIN-1:0]        pad_oe_n_w;
  logic [NPIN-1:0]        analog_w;
  logic [NPIN*FUNC_W-1:0] func_w;
  logic [DW-1:0]          lock_lo2;
  logic [DW-1:0]          lock_hi2;
  logic [NPIN*MUX_W-1:0]  gmux_all;

  assign gmux_all = {s_q.gmux_high_q, s_q.gmux_low_q};

  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    // Digital driver is released while the analog path owns the pad
    assign analog_w[i] = s_q.analog_sel_q[i] & ANALOG_PINS[i];
    always_comb begin
      if (analog_w[i]) begin
        pad_out_w[i]  = 1'b0;
        pad_oe_n_w[i] = 1'b1;
      end else if (s_q.open_drain_q[i]) begin
        pad_out_w[i]  = 1'b0;
        pad_oe_n_w[i] = ~pin_direction[i] | pin_out_data[i];
      end else begin
        pad_out_w[i]  = pin_out_data[i];
        pad_oe_n_w[i] = ~pin_direction[i];
      end
    end
    assign func_w[i*FUNC_W +: FUNC_W] =
      {gmux_all[i*MUX_W +: MUX_W], primary_mux[i*MUX_W +: MUX_W]};
  end

  for (genvar k = 0; k < HALF; k++) begin : g_lock2
    // Lock bit spread over the two bits of each mux field
    assign lock_lo2[k*MUX_W +: MUX_W] = {MUX_W{s_q.lock_q[k]}};
    assign lock_hi2[k*MUX_W +: MUX_W] = {MUX_W{s_q.lock_q[k+HALF]}};
  end

  always_comb begin
    s_d = s_q;
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_OPEN_DRAIN: begin
          s_d.open_drain_q = (s_q.open_drain_q & s_q.lock_q)
                           | (bus_req.wdata & ~s_q.lock_q);
        end
        OFS_ANALOG_SEL: begin
          s_d.analog_sel_q = (s_q.analog_sel_q & s_q.lock_q)
                           | (bus_req.wdata & ~s_q.lock_q);
        end
        OFS_GMUX_LOW: begin
          s_d.gmux_low_q = (s_q.gmux_low_q & lock_lo2)
                         | (bus_req.wdata & ~lock_lo2);
        end
        OFS_GMUX_HIGH: begin
          s_d.gmux_high_q = (s_q.gmux_high_q & lock_hi2)
                          | (bus_req.wdata & ~lock_hi2);
        end
        OFS_LOCK: begin
          s_d.lock_q = (s_q.lock_q & s_q.commit_q)
                     | (bus_req.wdata & ~s_q.commit_q);
        end
        OFS_COMMIT: begin
          // Ones stick; zeros cannot undo a commit short of reset
          s_d.commit_q = s_q.commit_q | bus_req.wdata;
        end
        default: begin
          s_d.commit_q = s_q.commit_q;
        end
      endcase
    end
    s_d.rdata_q = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_OPEN_DRAIN: s_d.rdata_q = s_q.open_drain_q;
        OFS_ANALOG_SEL: s_d.rdata_q = s_q.analog_sel_q;
        OFS_GMUX_LOW:   s_d.rdata_q = s_q.gmux_low_q;
        OFS_GMUX_HIGH:  s_d.rdata_q = s_q.gmux_high_q;
        OFS_LOCK:       s_d.rdata_q = s_q.lock_q;
        OFS_COMMIT:     s_d.rdata_q = s_q.commit_q;
        default:        s_d.rdata_q = '0;
      endcase
    end
    s_d.pad_out_q   = pad_out_w;
    s_d.pad_oe_n_q  = pad_oe_n_w;
    s_d.analog_en_q = analog_w;
    s_d.func_sel_q  = func_w;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q.open_drain_q <= RST_OPEN_DRAIN;
      s_q.analog_sel_q <= RST_ANALOG_SEL;
      s_q.gmux_low_q   <= RST_GMUX;
      s_q.gmux_high_q  <= RST_GMUX;
      s_q.lock_q       <= RST_LOCK;
      s_q.commit_q     <= RST_COMMIT;
      s_q.rdata_q      <= '0;
      s_q.pad_out_q    <= '0;
      s_q.pad_oe_n_q   <= '1;
      s_q.analog_en_q  <= '0;
      s_q.func_sel_q   <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus_rdata = s_q.rdata_q;
  assign pad_out   = s_q.pad_out_q;
  assign pad_oe_n  = s_q.pad_oe_n_q;
  assign analog_en = s_q.analog_en_q;
  assign func_sel  = s_q.func_sel_q;
  // Gates the primary mux, direction, inversion and channel-select writes elsewhere
  assign pin_lock  = s_q.lock_q;
endmodule

//--- src/gpacl_pkg.sv
// Constants and types for the port A configuration and lock block
package gpacl_pkg;
  localparam int unsigned NPIN = 32;
  localparam int unsigned AW   = 8;
  localparam int unsigned DW   = 32;

  // Register offsets
  localparam logic [AW-1:0] OFS_OPEN_DRAIN = 8'h12;
  localparam logic [AW-1:0] OFS_ANALOG_SEL = 8'h14;
  localparam logic [AW-1:0] OFS_GMUX_LOW   = 8'h20;
  localparam logic [AW-1:0] OFS_GMUX_HIGH  = 8'h22;
  localparam logic [AW-1:0] OFS_LOCK       = 8'h3c;
  localparam logic [AW-1:0] OFS_COMMIT     = 8'h3e;

  // Reset values
  localparam logic [DW-1:0] RST_OPEN_DRAIN = 32'h0000_0000;
  localparam logic [DW-1:0] RST_ANALOG_SEL = 32'hffff_ffff;
  localparam logic [DW-1:0] RST_GMUX       = 32'h0000_0000;
  localparam logic [DW-1:0] RST_LOCK       = 32'h0000_0000;
  localparam logic [DW-1:0] RST_COMMIT     = 32'h0000_0000;

  // Pins 28, 21, 20, 13, 12 share an analog pad
  localparam logic [DW-1:0] ANALOG_PINS    = 32'h1030_3000;

  // Field layout of one group-mux or primary-mux entry
  localparam int unsigned MUX_W  = 2;
  localparam int unsigned HALF   = 16;
  localparam int unsigned FUNC_W = 2 * MUX_W;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } gpacl_req_t;

  typedef struct packed {
    logic [NPIN-1:0]        open_drain_q;
    logic [NPIN-1:0]        analog_sel_q;
    logic [DW-1:0]          gmux_low_q;
    logic [DW-1:0]          gmux_high_q;
    logic [NPIN-1:0]        lock_q;
    logic [NPIN-1:0]        commit_q;
    logic [DW-1:0]          rdata_q;
    logic [NPIN-1:0]        pad_out_q;
    logic [NPIN-1:0]        pad_oe_n_q;
    logic [NPIN-1:0]        analog_en_q;
    logic [NPIN*FUNC_W-1:0] func_sel_q;
  } gpacl_state_t;
endpackage

//--- verif/gpacl_chk.sv
// Port-level assertions for the port A configuration block
`timescale 1ns/100ps
module gpacl_chk
  import gpacl_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    rstn,
  input wire gpacl_req_t              bus_req,
  input wire logic [DW-1:0]           bus_rdata,
  input wire logic [NPIN*MUX_W-1:0]   primary_mux,
  input wire logic [NPIN-1:0]         pin_direction,
  input wire logic [NPIN-1:0]         pin_out_data,
  input wire logic [NPIN-1:0]         pad_out,
  input wire logic [NPIN-1:0]         pad_oe_n,
  input wire logic [NPIN-1:0]         analog_en,
  input wire logic [NPIN*FUNC_W-1:0]  func_sel,
  input wire logic [NPIN-1:0]         pin_lock
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_AN_MASK: assert property ((analog_en & ~ANALOG_PINS) == '0)
    else $error("analog enable on digital pin");
  AST_AN_PAD: assert property (analog_en[12] |-> pad_oe_n[12] && !pad_out[12])
    else $error("analog pad still driven");
  AST_AN_RST: assert property ($rose(rstn) |=> analog_en == ANALOG_PINS)
    else $error("analog enable wrong after reset");
  AST_LOCK_RST: assert property ($rose(rstn) |-> pin_lock == '0)
    else $error("lock not clear after reset");
  AST_RD_IDLE: assert property ($past(rstn) && !$past(bus_req.rd) |-> bus_rdata == '0)
    else $error("read data without read");
  AST_FSEL: assert property ($past(rstn) |-> func_sel[1:0] == $past(primary_mux[1:0]))
    else $error("primary field lost");
  AST_DRV_DIR: assert property ($past(rstn) && !pad_oe_n[0] |-> $past(pin_direction[0]))
    else $error("input pin driven");
  AST_DRV_VAL: assert property (!pad_oe_n[0] |-> pad_out[0] == $past(pin_out_data[0]))
    else $error("driven level wrong");
  cover property (bus_req.wr && bus_req.addr == OFS_COMMIT);
  cover property (!pad_oe_n[0] && !pad_out[0]);
  cover property (analog_en == ANALOG_PINS);
endmodule
bind gpacl_top gpacl_chk u_chk (.clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .primary_mux(primary_mux), .pin_direction(pin_direction), .pin_out_data(pin_out_data),
  .pad_out(pad_out), .pad_oe_n(pad_oe_n), .analog_en(analog_en), .func_sel(func_sel),
  .pin_lock(pin_lock));

//--- verif/gpacl_test.sv
// Self-checking bench for the port A configuration block
`timescale 1ns/100ps
module gpacl_test;
  import gpacl_pkg::*;
  localparam logic [7:0] A [4] = '{OFS_OPEN_DRAIN, OFS_ANALOG_SEL, OFS_GMUX_LOW, OFS_GMUX_HIGH};
  logic         clk = 0, rstn = 0, rd_p = 0;
  gpacl_req_t   req = '0;
  logic [63:0]  pmux = '0;
  logic [127:0] fsel;
  logic [31:0]  dir = '0, dout = '0, rdata, pout, poen, aen, plock, r, l, c, m [4], ml [4];
  logic [31:0]  exp_q [$];
  int           mismatches = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  gpacl_top DUT (.clk(clk), .rstn(rstn), .bus_req(req), .bus_rdata(rdata), .primary_mux(pmux),
    .pin_direction(dir), .pin_out_data(dout), .pad_out(pout), .pad_oe_n(poen),
    .analog_en(aen), .func_sel(fsel), .pin_lock(plock));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Strobes stay one cycle; cleared so none lingers into reset
  task automatic op(logic [7:0] a, logic [31:0] d, logic w, logic rd);
    @(posedge clk);
    req <= '{a, d, w, rd};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rdx(logic [7:0] a, logic [31:0] e);
    op(a, '0, 0, 1);
    exp_q.push_back(e);
  endtask
  task automatic idle();
    op(8'h00, '0, 0, 0);
    repeat (2) @(negedge clk);
  endtask
  task automatic rst();
    @(posedge clk) rstn <= 0;
    repeat (4) @(posedge clk);
    rstn <= 1;
  endtask
  always @(posedge clk) rd_p <= req.rd;
  always @(negedge clk) if (rd_p) chk("bus_rdata", exp_q.pop_front(), rdata);
  initial begin
    void'($urandom(32'h3ff30601));
    rst();
    m = '{RST_OPEN_DRAIN, RST_ANALOG_SEL, RST_GMUX, RST_GMUX};
    foreach (A[i]) rdx(A[i], m[i]);
    rdx(OFS_LOCK, RST_LOCK);
    op(8'h30, '1, 1, 0);
    rdx(8'h30, '0);
    $display("test reset values done");
    op(OFS_OPEN_DRAIN, 32'h1, 1, 0);
    op(OFS_ANALOG_SEL, '0, 1, 0);
    dir <= 32'h1;
    dout <= 32'h1;
    idle();
    chk("pad_oe_n", '1, poen);
    chk("analog_en", '0, aen);
    @(posedge clk) dout <= '0;
    idle();
    chk("pad_oe_n", 32'hffff_fffe, poen);
    chk("pad_out", '0, pout & 32'h1);
    op(OFS_OPEN_DRAIN, '0, 1, 0);
    dout <= '1;
    idle();
    chk("pad_out", 32'h1, pout & 32'h1);
    op(OFS_ANALOG_SEL, '1, 1, 0);
    dir <= '1;
    idle();
    chk("analog_en", ANALOG_PINS, aen);
    chk("pad_oe_n", ANALOG_PINS, poen);
    $display("test pad path done");
    pmux <= {$urandom, $urandom};
    foreach (A[i]) begin
      m[i] = $urandom;
      op(A[i], m[i], 1, 0);
      rdx(A[i], m[i]);
    end
    idle();
    chk("func_sel", {m[2][1:0], pmux[1:0]}, fsel[3:0]);
    chk("func_sel", {m[3][31:30], pmux[63:62]}, fsel[127:124]);
    $display("test write read done");
    l = $urandom;
    op(OFS_LOCK, l, 1, 0);
    rdx(OFS_LOCK, l);
    chk("pin_lock", l, plock);
    // Group-mux fields are two bits per pin, so the lock mask spreads
    for (int j = 0; j < 32; j++) begin
      ml[2][j] = l[j/2];
      ml[3][j] = l[16+j/2];
    end
    ml[0] = l;
    ml[1] = l;
    foreach (A[i]) begin
      r = $urandom;
      op(A[i], r, 1, 0);
      rdx(A[i], (m[i] & ml[i]) | (r & ~ml[i]));
    end
    $display("test lock done");
    c = $urandom;
    op(OFS_COMMIT, c, 1, 0);
    op(OFS_COMMIT, '0, 1, 0);
    r = $urandom;
    op(OFS_LOCK, r, 1, 0);
    rdx(OFS_LOCK, (l & c) | (r & ~c));
    rdx(OFS_COMMIT, c);
    rst();
    rdx(OFS_COMMIT, '0);
    rdx(OFS_LOCK, '0);
    $display("test commit done");
    idle();
    report_and_stop();
  end
  initial begin
    #(25 * 600);
    mismatches++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
endmodule
